/* rtl/tws_pkg.sv */
// Behaviour
// - respond only when received address equals upper seven own-address bits
// - own-address bit 0 set enables response to general call 0x00
// - matched address with write bit enters slave receive, read bit otherwise; here a read address is not acknowledged and the slave goes back to idle
// - own address plus write received sets event flag and valid status
// - addressed after lost arbitration reports 0x68 own or 0x78 general call
// - ack enable cleared mid-transfer gives not-acknowledge after next byte
// - ack enable zero: own address not acknowledged, bus still watched
// - with interface clock stopped, address match via bus clock wakes part
// - after waking match, SCL held low until software clears event flag
// - data register need not hold last bus byte after such wake-up
// - status 0x60: own address with write received and acknowledged
// - status 0x70: general call received and acknowledged
// - status 0x80: data acknowledged under own address, byte in data register
// - clearing flag in addressed states receives next byte, acked per ack enable
// - status 0x88: data not acknowledged, then not-addressed slave
// - leaving 0x88, recognition follows ack enable and general call enable
// - status 0x78: lost arbitration then general call acknowledged
package tws_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_ADDR = 2'h3;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int B_EVENT_FLAG = 7;
  localparam int B_ACK_ENABLE = 6;
  localparam int B_START_REQUEST = 5;
  localparam int B_STOP_REQUEST = 4;
  localparam int B_WRITE_COLLISION = 3;
  localparam int B_INTERFACE_ENABLE = 2;
  localparam int B_IRQ_ENABLE = 0;
  localparam int B_GENERAL_CALL_ENABLE = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_OWN_ADDR = 8'hFE;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
  localparam logic [7:0] ST_GCALL = 8'h70;
  localparam logic [7:0] ST_ARB_GCALL = 8'h78;
  localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_RESTART = 8'hA0;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;
  localparam logic [7:0] GENERAL_CALL_ADDRESS = 8'h00;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } tws_bus_req_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AWAIT = 3'b010,
    S_AACK = 3'b011,
    S_HOLD = 3'b100,
    S_DATA = 3'b101,
    S_DWAIT = 3'b110,
    S_DACK = 3'b111
  } tws_state_t;
endpackage

/* rtl/tws_slave_rx.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire tws_pkg::tws_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // system
  input wire logic arb_lost,
  input wire logic sleep_mode,
  output logic wake_req
);
  import tws_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic event_flag;
  logic ack_enable;
  logic start_request;
  logic stop_request;
  logic interface_enable;
  logic irq_enable;
  logic [7:0] own_address_reg;
  logic [7:0] link_data_reg;
  logic [7:0] status_code;
  logic [1:0] prescale;
  tws_state_t st;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic gc_sel;
  logic ack_next;
  logic nacked;

  // ---------------------------------------------------------------
  // pin synchronisers and bus events
  // ---------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic own_hit, gc_hit, addr_hit, flag_clear, addressed;
  assign own_hit = (shift[7:1] == own_address_reg[7:1]);
  assign gc_hit = (shift == GENERAL_CALL_ADDRESS) & own_address_reg[B_GENERAL_CALL_ENABLE];
  assign addr_hit = interface_enable & ack_enable & ((own_hit & ~shift[0]) | gc_hit);
  assign flag_clear = bus_req.wr & (bus_req.addr == REG_CTRL) & bus_req.wdata[B_EVENT_FLAG];
  assign addressed = (st == S_AACK) | (st == S_DATA) | (st == S_DWAIT) | (st == S_DACK);

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= S_IDLE;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      gc_sel <= 1'b0;
      ack_next <= 1'b0;
      nacked <= 1'b0;
    end else if (!interface_enable || bus_stop) begin
      st <= S_IDLE;
    end else if (bus_start) begin
      st <= S_ADDR;
      bit_cnt <= 3'h0;
    end else begin
      case (st)
        S_IDLE: begin
          st <= S_IDLE;
        end
        S_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              st <= S_AWAIT;
            end
          end
        end
        S_AWAIT: begin
          // read direction and misses drop back to watching
          if (scl_fall) begin
            st <= addr_hit ? S_AACK : S_IDLE;
            gc_sel <= gc_hit;
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            st <= S_HOLD;
            nacked <= 1'b0;
          end
        end
        S_HOLD: begin
          if (flag_clear) begin
            st <= nacked ? S_IDLE : S_DATA;
            ack_next <= bus_req.wdata[B_ACK_ENABLE];
            bit_cnt <= 3'h0;
          end
        end
        S_DATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              st <= S_DWAIT;
            end
          end
        end
        S_DWAIT: begin
          if (scl_fall) begin
            st <= S_DACK;
            // ack decided late, so a mid-byte ack enable clear still counts
            ack_next <= ack_enable;
          end
        end
        S_DACK: begin
          if (scl_fall) begin
            st <= S_HOLD;
            nacked <= ~ack_next;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_oe <= ((st == S_AWAIT) & scl_fall & addr_hit & ~bus_start & ~bus_stop)
        | ((st == S_AACK) & ~scl_fall)
        | ((st == S_DWAIT) & scl_fall & ack_enable & ~bus_start & ~bus_stop)
        | ((st == S_DACK) & ack_next & ~scl_fall);
      scl_oe <= (st == S_HOLD) & event_flag & ~flag_clear;
    end
  end

  // ---------------------------------------------------------------
  // event flag and status
  // ---------------------------------------------------------------
  logic set_flag;
  logic [7:0] next_code;
  always_comb begin
    set_flag = 1'b0;
    next_code = status_code;
    if (addressed && (bus_stop || bus_start)) begin
      set_flag = 1'b1;
      next_code = ST_STOP_RESTART;
    end else if (st == S_AACK && scl_fall) begin
      set_flag = 1'b1;
      if (gc_sel) begin
        next_code = arb_lost ? ST_ARB_GCALL : ST_GCALL;
      end else begin
        next_code = arb_lost ? ST_ARB_OWN_W : ST_OWN_W;
      end
    end else if (st == S_DACK && scl_fall) begin
      set_flag = 1'b1;
      if (gc_sel) begin
        next_code = ack_next ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
      end else begin
        next_code = ack_next ? ST_OWN_DATA_ACK : ST_OWN_DATA_NACK;
      end
    end else if (flag_clear && !event_flag) begin
      next_code = ST_NO_INFO;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_flag <= 1'b0;
      status_code <= ST_NO_INFO;
    end else begin
      status_code <= flag_clear & ~set_flag ? ST_NO_INFO : next_code;
      // hardware set beats software clear
      if (set_flag) begin
        event_flag <= 1'b1;
      end else if (flag_clear) begin
        event_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wake_req <= 1'b0;
    end else if (st == S_AACK && scl_fall && sleep_mode) begin
      wake_req <= 1'b1;
    end else if (flag_clear) begin
      wake_req <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      interface_enable <= 1'b0;
      irq_enable <= 1'b0;
      own_address_reg <= RST_OWN_ADDR;
      prescale <= RST_PRESCALE;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        REG_CTRL: begin
          ack_enable <= bus_req.wdata[B_ACK_ENABLE];
          start_request <= bus_req.wdata[B_START_REQUEST];
          stop_request <= bus_req.wdata[B_STOP_REQUEST];
          interface_enable <= bus_req.wdata[B_INTERFACE_ENABLE];
          irq_enable <= bus_req.wdata[B_IRQ_ENABLE];
        end
        REG_STAT: begin
          prescale <= bus_req.wdata[1:0];
        end
        REG_ADDR: begin
          own_address_reg <= bus_req.wdata;
        end
        default: begin
          prescale <= prescale;
        end
      endcase
    end
  end

  // received bytes are not captured while sleeping, saving the update
  always_ff @(posedge clk) begin
    if (srst) begin
      link_data_reg <= RST_DATA;
    end else if (st == S_DACK && scl_fall && !sleep_mode) begin
      link_data_reg <= shift;
    end else if (bus_req.wr && bus_req.addr == REG_DATA) begin
      link_data_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        REG_CTRL: rd_data <= {event_flag, ack_enable, start_request, stop_request,
                              1'b0, interface_enable, 1'b0, irq_enable};
        REG_STAT: rd_data <= {status_code[7:3], 1'b0, prescale};
        REG_DATA: rd_data <= link_data_reg;
        REG_ADDR: rd_data <= own_address_reg;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_stretch;
    (st == S_HOLD && event_flag && !flag_clear) |=> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not stretched");

  property p_own_ack;
    (st == S_AWAIT && scl_fall && !bus_start && !bus_stop && interface_enable && ack_enable
      && own_hit && !shift[0]) |=> sda_oe && st == S_AACK;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acked");

  property p_gc_off;
    (st == S_AWAIT && scl_fall && shift == GENERAL_CALL_ADDRESS
      && !own_address_reg[B_GENERAL_CALL_ENABLE] && own_address_reg[7:1] != 7'h00)
      |=> !sda_oe;
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("general call acked while off");

  property p_read_ignored;
    (st == S_AWAIT && scl_fall && shift[0] && shift != 8'hFF) |=> st != S_AACK;
  endproperty
  a_read_ignored: assert property (p_read_ignored) else $error("read entered receive");

  property p_no_ack_disabled;
    (st == S_AWAIT && scl_fall && !ack_enable) |=> !sda_oe ##1 !sda_oe;
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("acked while off");

  property p_nack;
    (st == S_DACK && !ack_next) |-> !sda_oe;
  endproperty
  a_nack: assert property (p_nack) else $error("data acked while disabled");

  property p_code60;
    (st == S_AACK && scl_fall && !gc_sel && !arb_lost && !bus_start && !bus_stop)
      |=> event_flag && status_code == ST_OWN_W;
  endproperty
  a_code60: assert property (p_code60) else $error("own address code wrong");

  property p_code70;
    (st == S_AACK && scl_fall && gc_sel && !arb_lost && !bus_start && !bus_stop)
      |=> event_flag && status_code == ST_GCALL;
  endproperty
  a_code70: assert property (p_code70) else $error("general call code wrong");

  property p_code80;
    (st == S_DACK && scl_fall && ack_next && !gc_sel && !sleep_mode && !bus_start && !bus_stop)
      |=> status_code == ST_OWN_DATA_ACK && link_data_reg == $past(shift);
  endproperty
  a_code80: assert property (p_code80) else $error("data code or byte wrong");

  property p_leave88;
    (st == S_HOLD && nacked && flag_clear && !bus_stop && !bus_start && interface_enable)
      |=> st == S_IDLE;
  endproperty
  a_leave88: assert property (p_leave88) else $error("still addressed after nack");

  property p_wake_hold;
    (wake_req && st == S_HOLD && event_flag && !flag_clear) |=> scl_oe;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("clock released during wake");
endmodule // tws_slave_rx
`default_nettype wire

/* test/tws_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_master_model (
  // clock
  input wire logic clk,
  // bus wire levels and master pull-downs, 1 = released
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_m,
  output logic sda_m
);
  // idle bus: both lines released to the pull-ups, clock stands still
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // release scl and wait out a slave's stretch, bounded so a stuck slave cannot hang us
  task automatic rise();
    int i;
    i = 0;
    scl_m <= 1'b1;
    @(posedge clk);
    while (scl_w !== 1'b1 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    tick(3);
  endtask

  task automatic start();
    sda_m <= 1'b0;
    tick(8);
    scl_m <= 1'b0;
    tick(4);
  endtask

  // one bit: 8 cycles low, 8 high, sampled mid-high
  task automatic put_bit(input logic b, output logic r);
    sda_m <= b;
    tick(4);
    rise();
    r = sda_w;
    tick(4);
    scl_m <= 1'b0;
    tick(4);
  endtask

  // msb first, then sda released for the slave's ack
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) begin
      put_bit(d[k], r);
    end
    put_bit(1'b1, ack);
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    tick(4);
    rise();
    tick(4);
    sda_m <= 1'b1;
    tick(8);
  endtask
endmodule // tws_master_model
`default_nettype wire

/* test/tws_slave_rx_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx_bench;
  import tws_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  tws_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic scl_out, scl_oe, sda_out, sda_oe, wake_req;
  logic arb_lost = 1'b0;
  logic sleep_mode = 1'b0;
  logic scl_m, sda_m, scl_w, sda_w;
  logic [7:0] v;
  logic a;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  always #5 clk = ~clk;
  // open drain wires with pull-ups
  assign scl_w = scl_m & ~(scl_oe & ~scl_out);
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);

  tws_slave_rx u_dut (
    .clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .arb_lost(arb_lost), .sleep_mode(sleep_mode), .wake_req(wake_req)
  );
  tws_master_model u_mst (
    .clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [1:0] ad, input logic [7:0] m, input logic [7:0] e);
    rd(ad, v);
    chk(v & m, e);
  endtask

  // address phase; when acked, status and stretch are checked
  task automatic open_xfer(input logic [7:0] ab, input logic ea, input logic [7:0] es);
    u_mst.start();
    u_mst.send_byte(ab, a);
    chk({7'h00, a}, {7'h00, ea});
    if (ea === 1'b0) begin
      rchk(REG_STAT, 8'hF8, es);
      chk({7'h00, scl_oe}, 8'h01);
    end else begin
      u_mst.stop();
    end
  endtask

  // nack one byte, leave to not addressed, stop
  task automatic close_xfer(input logic [7:0] es);
    wr(REG_CTRL, 8'h84);
    u_mst.send_byte(8'hFF, a);
    chk({7'h00, a}, 8'h01);
    rchk(REG_STAT, 8'hF8, es);
    wr(REG_CTRL, 8'hC4);
    u_mst.stop();
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // timeout, about twelve times the expected run
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rchk(REG_CTRL, 8'hFF, 8'h00);
    rchk(REG_STAT, 8'hFF, 8'hF8);
    rchk(REG_DATA, 8'hFF, 8'hFF);
    rchk(REG_ADDR, 8'hFF, 8'hFE);
    wr(REG_ADDR, 8'h55);
    rchk(REG_ADDR, 8'hFF, 8'h55);
    $display("test reset done");
    wr(REG_CTRL, 8'h44);
    open_xfer(8'h54, 1'b0, 8'h60);
    wr(REG_CTRL, 8'hC4);
    u_mst.send_byte(8'hA5, a);
    chk({7'h00, a}, 8'h00);
    rchk(REG_STAT, 8'hF8, 8'h80);
    rchk(REG_DATA, 8'hFF, 8'hA5);
    wr(REG_CTRL, 8'hC4);
    wr(REG_CTRL, 8'h04);
    u_mst.send_byte(8'h3C, a);
    chk({7'h00, a}, 8'h01);
    rchk(REG_STAT, 8'hF8, 8'h88);
    rchk(REG_DATA, 8'hFF, 8'h3C);
    wr(REG_CTRL, 8'hC4);
    u_mst.stop();
    $display("test own address done");
    open_xfer(8'h00, 1'b0, 8'h70);
    wr(REG_CTRL, 8'hC4);
    u_mst.send_byte(8'h5A, a);
    chk({7'h00, a}, 8'h00);
    rchk(REG_STAT, 8'hF8, 8'h90);
    close_xfer(8'h98);
    open_xfer(8'h54, 1'b0, 8'h60);
    wr(REG_CTRL, 8'hC4);
    u_mst.stop();
    rchk(REG_STAT, 8'hF8, 8'hA0);
    wr(REG_CTRL, 8'hC4);
    rchk(REG_STAT, 8'hF8, 8'hF8);
    $display("test general call and stop done");
    open_xfer(8'h56, 1'b1, 8'h00);
    open_xfer(8'h55, 1'b1, 8'h00);
    wr(REG_ADDR, 8'h54);
    open_xfer(8'h00, 1'b1, 8'h00);
    $display("test address filter done");
    wr(REG_CTRL, 8'h04);
    open_xfer(8'h54, 1'b1, 8'h00);
    wr(REG_CTRL, 8'h44);
    open_xfer(8'h54, 1'b0, 8'h60);
    close_xfer(8'h88);
    $display("test ack enable done");
    arb_lost <= 1'b1;
    wr(REG_ADDR, 8'h55);
    open_xfer(8'h54, 1'b0, 8'h68);
    close_xfer(8'h88);
    open_xfer(8'h00, 1'b0, 8'h78);
    close_xfer(8'h98);
    arb_lost <= 1'b0;
    $display("test lost arbitration done");
    sleep_mode <= 1'b1;
    open_xfer(8'h54, 1'b0, 8'h60);
    chk({7'h00, wake_req}, 8'h01);
    repeat (100) @(posedge clk);
    chk({7'h00, scl_oe}, 8'h01);
    sleep_mode <= 1'b0;
    close_xfer(8'h88);
    chk({7'h00, wake_req}, 8'h00);
    $display("test sleep wake done");
    results();
  end
endmodule // tws_slave_rx_bench
`default_nettype wire
